// >>> design/coupler_pkg.sv
// shared constants and carrier types for the coupler start-up and process image
package coupler_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned MAX_TERMS   = 16;   // terminals probed on the terminal bus
  localparam int unsigned IMG_BYTES   = 64;   // bytes per process image area
  localparam int unsigned TIDX_W      = 4;
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned BITADDR_W   = 9;    // byte address plus bit number

  // ---------------------------------------------------------------------------
  // timing and values
  // ---------------------------------------------------------------------------
  localparam int unsigned SELFTEST_CYC = 64;          // self-test cycles
  localparam int unsigned BLINK_HALF   = 32;          // blink half period, cycles
  localparam logic [6:0]  BLINK_HALF_C = 7'h20;
  localparam logic [6:0]  SELFTEST_C   = 7'h40;
  localparam logic [15:0] ANA_ZERO     = 16'h0000;    // 0 V, 0 mA or 4 mA
  localparam logic [15:0] ANA_POS_FULL = 16'h7FFF;
  localparam logic [15:0] ANA_NEG_FULL = 16'h1000;
  localparam logic [15:0] RES12_MASK   = 16'hFFF8;    // low 3 bits dropped at 12-bit
  localparam logic [3:0]  ANA_BYTES    = 4'h2;        // data bytes of an analog channel

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_SELFTEST = 5'b00001,
    ST_PROBE    = 5'b00010,
    ST_LAYOUT   = 5'b00100,
    ST_STOP     = 5'b01000,
    ST_RUN      = 5'b10000
  } phase_e;

  // description of one terminal as read in during probing
  typedef struct packed {
    logic       byte_oriented;  // analog, serial, encoder and other complex
    logic       has_out;
    logic       has_in;
    logic       res12;          // only 12 bits of real resolution
    logic [3:0] out_width;      // bytes (byte type) or bits (bit type)
    logic [3:0] in_width;
  } term_desc_s;

  // one entry of the internal assignment list
  typedef struct packed {
    logic [BITADDR_W-1:0] out_base;
    logic [BITADDR_W-1:0] in_base;
  } slot_s;

  // scanner side access, one whole unit of bytes at a time
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0]  len;       // bytes moved as one unit
    logic [31:0] data;
  } scan_req_s;

endpackage

// >>> design/coupler_selftest.sv
// self-test timer and error indicator blinker
`timescale 1ns/1ps
module coupler_selftest (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic blink_en_i,
  input  wire logic bus_ok_i,
  output logic      done_o,
  output logic      fail_o,
  output logic      blink_o
);
  logic [6:0] cnt;
  logic [6:0] bcnt;
  wire        half_w = (bcnt == coupler_pkg::BLINK_HALF_C - 7'h01);

  // ---------------------------------------------------------------------------
  // test timer: terminal bus echo must be good when it expires
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt    <= 7'h00;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end else if (!done_o) begin
      cnt <= cnt + 7'h01;
      if (cnt == coupler_pkg::SELFTEST_C - 7'h01) begin
        done_o <= 1'b1;
        fail_o <= !bus_ok_i;
      end
    end
  end

  // blink toggles only while enabled, off otherwise
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bcnt    <= 7'h00;
      blink_o <= 1'b0;
    end else if (!blink_en_i) begin
      bcnt    <= 7'h00;
      blink_o <= 1'b0;
    end else begin
      bcnt <= half_w ? 7'h00 : bcnt + 7'h01;
      if (half_w) blink_o <= !blink_o;
    end
  end
endmodule

// >>> design/coupler_analog.sv
// analog word conditioning between terminal and process image
`timescale 1ns/1ps
module coupler_analog (
  input  wire logic        res12_i,
  input  wire logic [15:0] from_term_i,
  input  wire logic [15:0] from_image_i,
  output logic      [15:0] to_image_o,
  output logic      [15:0] to_term_o
);
  // signed word passes through; at 12 bits the low three bits are forced zero
  wire [15:0] mask_w = res12_i ? coupler_pkg::RES12_MASK : 16'hFFFF;
  assign to_image_o = from_term_i & mask_w;
  assign to_term_o  = from_image_i & mask_w;
endmodule

// >>> design/coupler_core.sv
// start-up sequencer and process image assembly of the fieldbus coupler
`timescale 1ns/1ps

// How it works
// - self-test at power-up, red indicator blinks
// - probe terminals, build hidden structure list
// - any start-up error enters stop state
// - clean start-up enters fieldbus start state
// - stop left only by power-on reset
// - separate in/out areas, bytes then bits
// - one bit per digital input, own area
// - digital outputs own area, driven immediately
// - analog channel is two signed bytes
// - zero, 7FFF and 1000 scale endpoints
// - 12-bit channels drop three low bits
// - control/status byte is top byte
// - variant 2.0 hides control/status byte
// - special interfaces mapped as wide bytes
// - list built from nearest terminal rightward
// - order: ana out, dig out, ana in, dig in
// - complex terminals go to byte groups
// - bits of a byte move together
// - multi-byte values move as one unit
module coupler_core (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    fw_v20_i,       // firmware variant 2.0
  input  wire logic                    term_bus_ok_i,  // loop-back of terminal bus
  input  wire logic                    term_valid_i,   // descriptor of probed terminal
  input  wire logic                    term_err_i,     // probe of this terminal failed
  input  wire logic                    term_last_i,    // no terminal to the right
  input  wire coupler_pkg::term_desc_s term_desc_i,
  output logic                         term_probe_o,   // ask next terminal
  input  wire coupler_pkg::scan_req_s  scan_i,
  output logic [31:0]                  scan_rdata_o,
  input  wire logic                    dig_in_i [coupler_pkg::MAX_TERMS][16],
  output logic                         dig_out_o [coupler_pkg::MAX_TERMS][16],
  input  wire logic [15:0]             ana_in_i [coupler_pkg::MAX_TERMS],
  input  wire logic [7:0]              ana_stat_i [coupler_pkg::MAX_TERMS],
  output logic [15:0]                  ana_out_o [coupler_pkg::MAX_TERMS],
  output logic [7:0]                   ana_ctrl_o [coupler_pkg::MAX_TERMS],
  output logic                         io_err_led_o,
  output logic                         io_run_led_o,
  output logic                         fieldbus_start_o,
  output logic                         stopped_o
);
  localparam int unsigned NT = coupler_pkg::MAX_TERMS;
  localparam int unsigned NB = coupler_pkg::IMG_BYTES;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  coupler_pkg::phase_e  phase;
  coupler_pkg::phase_e  next_phase;
  coupler_pkg::term_desc_s desc [NT];   // structure list, no outside port reads it
  coupler_pkg::slot_s      slot [NT];
  logic [coupler_pkg::TIDX_W-1:0] nterm;
  logic [coupler_pkg::TIDX_W-1:0] lay_idx;
  logic [1:0]                     lay_pass;   // four group passes
  logic [coupler_pkg::BITADDR_W-1:0] out_ptr;
  logic [coupler_pkg::BITADDR_W-1:0] in_ptr;
  logic [7:0] out_img [NB];             // output area
  logic [7:0] in_img  [NB];             // input area
  logic       st_done;
  logic       st_fail;
  logic       blink;
  logic       layout_err;

  coupler_selftest u_selftest (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .blink_en_i (phase != coupler_pkg::ST_RUN),
    .bus_ok_i   (term_bus_ok_i),
    .done_o     (st_done),
    .fail_o     (st_fail),
    .blink_o    (blink)
  );

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // bytes a byte-oriented channel takes; 2.0 leaves out the control byte
  function automatic logic [3:0] unit_bytes(input logic [3:0] w, input logic v20);
    logic [3:0] b;
    b = (w > coupler_pkg::ANA_BYTES) ? w : coupler_pkg::ANA_BYTES;
    unit_bytes = v20 ? b : b + 4'h1;
  endfunction

  // space a terminal takes in the current pass
  function automatic logic [coupler_pkg::BITADDR_W-1:0] take(
      input coupler_pkg::term_desc_s d, input logic [1:0] pass, input logic v20);
    logic [coupler_pkg::BITADDR_W-1:0] t;
    t = '0;
    unique case (pass)
      2'd0: if (d.byte_oriented && d.has_out) t = {2'b00, unit_bytes(d.out_width, v20), 3'b000};
      2'd1: if (!d.byte_oriented && d.has_out) t = {5'h00, d.out_width};
      2'd2: if (d.byte_oriented && d.has_in) t = {2'b00, unit_bytes(d.in_width, v20), 3'b000};
      2'd3: if (!d.byte_oriented && d.has_in) t = {5'h00, d.in_width};
    endcase
    take = t;
  endfunction

  // ---------------------------------------------------------------------------
  // sequencing decode
  // ---------------------------------------------------------------------------
  wire lay_end_w  = (lay_idx == nterm - 4'h1) && (lay_pass == 2'd3);
  wire probe_ok_w = term_valid_i && !term_err_i;
  // one spare bit on the sums so a channel running past the last byte is seen
  wire [coupler_pkg::BITADDR_W:0] out_sum_w = {1'b0, out_ptr} + {1'b0, take_w};
  wire [coupler_pkg::BITADDR_W:0] in_sum_w  = {1'b0, in_ptr} + {1'b0, take_w};
  wire img_over_w = (!lay_pass[1] && out_sum_w > 10'(NB * 8))
                 || (lay_pass[1] && in_sum_w > 10'(NB * 8));

  // next phase; stop has no exit, reset alone leaves it
  always_comb begin
    next_phase = phase;
    unique case (phase)
      coupler_pkg::ST_SELFTEST:
        if (st_done) next_phase = st_fail ? coupler_pkg::ST_STOP : coupler_pkg::ST_PROBE;
      coupler_pkg::ST_PROBE:
        if (term_valid_i && term_err_i) next_phase = coupler_pkg::ST_STOP;
        else if (probe_ok_w && (term_last_i || nterm == 4'(NT-1)))
          next_phase = coupler_pkg::ST_LAYOUT;
      coupler_pkg::ST_LAYOUT:
        if (layout_err || img_over_w) next_phase = coupler_pkg::ST_STOP;
        else if (lay_end_w) next_phase = coupler_pkg::ST_RUN;
      coupler_pkg::ST_STOP:
        next_phase = coupler_pkg::ST_STOP;
      coupler_pkg::ST_RUN:
        next_phase = coupler_pkg::ST_RUN;
      default:
        next_phase = coupler_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) phase <= coupler_pkg::ST_SELFTEST;
    else            phase <= next_phase;
  end

  // ---------------------------------------------------------------------------
  // probing: terminals arrive nearest first, stored in arrival order
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nterm        <= '0;
      term_probe_o <= 1'b0;
    end else begin
      term_probe_o <= (phase == coupler_pkg::ST_PROBE) && !term_valid_i;
      if (phase == coupler_pkg::ST_PROBE && probe_ok_w) begin
        desc[nterm] <= term_desc_i;
        nterm       <= nterm + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // layout: four passes over the list, each pass one group
  // ---------------------------------------------------------------------------
  wire [coupler_pkg::BITADDR_W-1:0] take_w = take(desc[lay_idx], lay_pass, fw_v20_i);
  wire pass_end_w = (lay_idx == nterm - 4'h1);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lay_idx    <= '0;
      lay_pass   <= 2'd0;
      out_ptr    <= '0;
      in_ptr     <= '0;
      layout_err <= 1'b0;
    end else if (phase == coupler_pkg::ST_LAYOUT) begin
      layout_err <= img_over_w;
      if (!lay_pass[1]) begin
        if (take_w != '0) slot[lay_idx].out_base <= out_ptr;
        out_ptr <= out_ptr + take_w;
      end else begin
        if (take_w != '0) slot[lay_idx].in_base <= in_ptr;
        in_ptr <= in_ptr + take_w;
      end
      lay_idx <= pass_end_w ? '0 : lay_idx + 4'h1;
      if (pass_end_w) begin
        lay_pass <= lay_pass + 2'd1;
        // byte group ends on whole byte before bit group starts
        if (lay_pass == 2'd0) out_ptr <= {out_ptr[8:3] + 6'(|out_ptr[2:0]), 3'b000} + take_w;
        if (lay_pass == 2'd2) in_ptr  <= {in_ptr[8:3] + 6'(|in_ptr[2:0]), 3'b000} + take_w;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // process image exchange with terminals
  // ---------------------------------------------------------------------------
  logic [15:0] ana_img_in  [NT];
  logic [15:0] ana_term_out[NT];
  for (genvar t = 0; t < NT; t++) begin : g_ana
    wire [5:0] ob = slot[t].out_base[8:3];
    coupler_analog u_ana (
      .res12_i      (desc[t].res12),
      .from_term_i  (ana_in_i[t]),
      .from_image_i ({out_img[6'(ob + 6'd1)], out_img[ob]}),
      .to_image_o   (ana_img_in[t]),
      .to_term_o    (ana_term_out[t])
    );
  end

  wire run_w = (phase == coupler_pkg::ST_RUN);

  // inputs sampled each cycle; whole bytes at once so a byte never tears
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int b = 0; b < NB; b++) in_img[b] <= 8'h00;
    end else if (run_w) begin
      for (int t = 0; t < NT; t++) begin
        if (4'(t) < nterm && desc[t].has_in) begin
          if (desc[t].byte_oriented) begin
            in_img[6'(slot[t].in_base[8:3])]        <= ana_img_in[t][7:0];
            in_img[6'(slot[t].in_base[8:3] + 6'd1)] <= ana_img_in[t][15:8];
            if (!fw_v20_i)
              in_img[6'(slot[t].in_base[8:3] + 6'd2)] <= ana_stat_i[t];
          end else begin
            for (int c = 0; c < 16; c++)
              if (4'(c) < desc[t].in_width)
                in_img[6'((slot[t].in_base + 9'(c)) >> 3)][3'(slot[t].in_base + 9'(c))]
                  <= dig_in_i[t][c];
          end
        end
      end
    end
  end

  // outputs follow the image with no delay beyond one register stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int t = 0; t < NT; t++) begin
        ana_out_o[t]  <= coupler_pkg::ANA_ZERO;
        ana_ctrl_o[t] <= 8'h00;
        for (int c = 0; c < 16; c++) dig_out_o[t][c] <= 1'b0;
      end
    end else if (run_w) begin
      for (int t = 0; t < NT; t++) begin
        ana_out_o[t]  <= ana_term_out[t];
        ana_ctrl_o[t] <= fw_v20_i ? 8'h00 : out_img[6'(slot[t].out_base[8:3] + 6'd2)];
        for (int c = 0; c < 16; c++)
          dig_out_o[t][c] <= !desc[t].byte_oriented && 4'(c) < desc[t].out_width
            && out_img[6'((slot[t].out_base + 9'(c)) >> 3)][3'(slot[t].out_base + 9'(c))];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // scanner access: a unit of up to four bytes moves in one cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int b = 0; b < NB; b++) out_img[b] <= 8'h00;
      scan_rdata_o <= 32'h0000_0000;
    end else if (run_w) begin
      for (int k = 0; k < 4; k++)
        if (scan_i.wr && 4'(k) < scan_i.len)
          out_img[6'(scan_i.addr + 6'(k))] <= scan_i.data[8*k +: 8];
      if (scan_i.rd)
        for (int k = 0; k < 4; k++)
          scan_rdata_o[8*k +: 8] <= (4'(k) < scan_i.len) ? in_img[6'(scan_i.addr + 6'(k))]
                                                          : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_err_led_o     <= 1'b0;
      io_run_led_o     <= 1'b0;
      fieldbus_start_o <= 1'b0;
      stopped_o        <= 1'b0;
    end else begin
      io_err_led_o     <= (next_phase == coupler_pkg::ST_STOP) ? 1'b1 : blink && !run_w;
      io_run_led_o     <= (next_phase == coupler_pkg::ST_RUN);
      fieldbus_start_o <= (next_phase == coupler_pkg::ST_RUN);
      stopped_o        <= (next_phase == coupler_pkg::ST_STOP);
    end
  end
endmodule

// >>> testbench/coupler_core_props.sv
// property checker for the coupler start-up sequencer
`timescale 1ns/1ps
module coupler_core_props (
  input wire logic                   clk_i,
  input wire logic                   reset_n_i,
  input wire logic                   term_bus_ok_i,
  input wire logic                   term_valid_i,
  input wire logic                   term_err_i,
  input wire logic                   term_probe_o,
  input wire coupler_pkg::scan_req_s scan_i,
  input wire logic [31:0]            scan_rdata_o,
  input wire logic                   io_err_led_o,
  input wire logic                   io_run_led_o,
  input wire logic                   fieldbus_start_o,
  input wire logic                   stopped_o
);
  logic [15:0] cyc_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // helpers
  // ----
  // cycles since reset release; saturates so long runs stay quiet
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_cnt <= 16'h0000;
    end else if (cyc_cnt != 16'hFFFF) begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end
  sequence fault_s;
    term_valid_i && term_err_i;
  endsequence
  sequence halted_s;
    stopped_o && !fieldbus_start_o && !io_run_led_o;
  endsequence
  // ----
  // properties
  // ----
  probe_after_test_a: assert property (term_probe_o |-> cyc_cnt >= 16'h003F)
    else $error("terminal probe during self-test");
  start_after_test_a: assert property (fieldbus_start_o |-> cyc_cnt > 16'h0040)
    else $error("fieldbus start before self-test end");
  probe_fault_a: assert property (fault_s |-> ##[1:8] halted_s)
    else $error("probe fault did not stop");
  loop_fault_a: assert property ((cyc_cnt == 16'h0040 && !term_bus_ok_i) |-> ##[1:8] halted_s)
    else $error("bus loop-back fault did not stop");
  stop_sticky_a: assert property (stopped_o |=> stopped_o)
    else $error("stop state left without reset");
  state_excl_a: assert property (!(stopped_o && fieldbus_start_o))
    else $error("stop and start together");
  start_hold_a: assert property ($rose(fieldbus_start_o) |-> fieldbus_start_o [*8])
    else $error("fieldbus start dropped");
  run_leds_a: assert property (fieldbus_start_o |-> ##[0:2] (io_run_led_o && !io_err_led_o))
    else $error("leds wrong in run");
  rdata_hold_a: assert property (!scan_i.rd |=> $stable(scan_rdata_o))
    else $error("read data changed without read");
  blink_c: cover property (cyc_cnt < 16'h0040 && $fell(io_err_led_o));
endmodule

bind coupler_core coupler_core_props chk_u (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .term_bus_ok_i(term_bus_ok_i),
  .term_valid_i(term_valid_i),
  .term_err_i(term_err_i),
  .term_probe_o(term_probe_o),
  .scan_i(scan_i),
  .scan_rdata_o(scan_rdata_o),
  .io_err_led_o(io_err_led_o),
  .io_run_led_o(io_run_led_o),
  .fieldbus_start_o(fieldbus_start_o),
  .stopped_o(stopped_o)
);

// >>> testbench/terminal_chain_model.sv
// behavioural chain of four I/O terminals answering the probe
`timescale 1ns/1ps
module terminal_chain_model (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               probe_i,
  input  wire logic               slow_i,    // long gaps between answers
  input  wire logic [3:0]         fail_at_i, // terminal whose probe fails
  output logic                    valid_o,
  output logic                    err_o,
  output logic                    last_o,
  output coupler_pkg::term_desc_s desc_o
);
  logic [3:0]              idx;
  logic [3:0]              gap;
  logic                    done;
  coupler_pkg::term_desc_s next_desc;
  // fixed chain, nearest terminal first
  always_comb begin
    case (idx)
      4'h0:    next_desc = {1'b1, 1'b1, 1'b1, 1'b0, 4'h2, 4'h2}; // analog in/out
      4'h1:    next_desc = {1'b0, 1'b1, 1'b0, 1'b0, 4'h4, 4'h0}; // four digital outs
      4'h2:    next_desc = {1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h4}; // four digital ins
      default: next_desc = {1'b1, 1'b1, 1'b1, 1'b1, 4'h2, 4'h2}; // 12-bit analog
    endcase
  end
  // one descriptor per probe; idle lines carry junk so nothing leans on stale values
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx <= 4'h0;
      gap <= 4'h0;
      done <= 1'b0;
      valid_o <= 1'b0;
      err_o <= 1'b0;
      last_o <= 1'b0;
      desc_o <= '0;
    end else if (probe_i && !done && gap == 4'h0) begin
      valid_o <= 1'b1;
      desc_o <= next_desc;
      err_o <= (idx == fail_at_i);
      last_o <= (idx == 4'h3);
      done <= (idx == 4'h3) || (idx == fail_at_i);
      idx <= idx + 4'h1;
      gap <= slow_i ? 4'h9 : 4'h2; // registered probe needs two edges to drop
    end else begin
      valid_o <= 1'b0;
      err_o <= ~err_o;
      last_o <= ~last_o;
      desc_o <= ~desc_o;
      if (gap != 4'h0) gap <= gap - 4'h1;
    end
  end
endmodule

// >>> testbench/tb_coupler_startup_process_image.sv
// self-checking bench for the coupler start-up and process image
`timescale 1ns/1ps
module tb_coupler_startup_process_image;
  typedef struct {
    logic        wr;
    logic [5:0]  addr;
    logic [3:0]  len;
    logic [31:0] data;
    int          kind; // 0 read back, 1 analog out, 2 digital out
    int          idx;
    logic [31:0] exp;
  } row_s;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic fw_v20_i = 1'b1;
  logic term_bus_ok_i = 1'b1;
  logic slow = 1'b0;
  logic [3:0] fail_at = 4'hF;
  logic term_valid_i, term_err_i, term_last_i, term_probe_o;
  logic io_err_led_o, io_run_led_o, fieldbus_start_o, stopped_o;
  coupler_pkg::term_desc_s term_desc_i;
  coupler_pkg::scan_req_s scan_i = '0;
  logic [31:0] scan_rdata_o;
  logic [31:0] got;
  logic dig_in_i [coupler_pkg::MAX_TERMS][16];
  logic dig_out_o [coupler_pkg::MAX_TERMS][16];
  logic [15:0] ana_in_i [coupler_pkg::MAX_TERMS];
  logic [7:0] ana_stat_i [coupler_pkg::MAX_TERMS];
  logic [15:0] ana_out_o [coupler_pkg::MAX_TERMS];
  logic [7:0] ana_ctrl_o [coupler_pkg::MAX_TERMS];
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // image: analog T0 bytes 0-1, T3 bytes 2-3, digital byte 4 (firmware 2.0)
  row_s rows [7] = '{
    '{1'b0, 6'h00, 4'h2, 32'h0, 0, 0, 32'h0000_8123},
    '{1'b0, 6'h02, 4'h2, 32'h0, 0, 0, 32'h0000_7FF8},
    '{1'b0, 6'h04, 4'h1, 32'h0, 0, 0, 32'h0000_000B},
    '{1'b1, 6'h00, 4'h2, 32'h0000_1000, 1, 0, 32'h0000_1000},
    '{1'b1, 6'h02, 4'h2, 32'h0000_7FFF, 1, 3, 32'h0000_7FF8},
    '{1'b1, 6'h04, 4'h1, 32'h0000_000A, 2, 1, 32'h0000_000A},
    '{1'b0, 6'h00, 4'h4, 32'h0, 0, 0, 32'h7FF8_8123}};
  always #2 clk_i = ~clk_i;
  coupler_core dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .fw_v20_i(fw_v20_i),
    .term_bus_ok_i(term_bus_ok_i), .term_valid_i(term_valid_i), .term_err_i(term_err_i),
    .term_last_i(term_last_i), .term_desc_i(term_desc_i), .term_probe_o(term_probe_o),
    .scan_i(scan_i), .scan_rdata_o(scan_rdata_o), .dig_in_i(dig_in_i), .dig_out_o(dig_out_o),
    .ana_in_i(ana_in_i), .ana_stat_i(ana_stat_i), .ana_out_o(ana_out_o),
    .ana_ctrl_o(ana_ctrl_o), .io_err_led_o(io_err_led_o), .io_run_led_o(io_run_led_o),
    .fieldbus_start_o(fieldbus_start_o), .stopped_o(stopped_o));
  terminal_chain_model chain_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .probe_i(term_probe_o),
    .slow_i(slow), .fail_at_i(fail_at), .valid_o(term_valid_i), .err_o(term_err_i),
    .last_o(term_last_i), .desc_o(term_desc_i));
  // ----
  // tasks
  // ----
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one whole unit per access; idle fields get junk so nothing leans on them
  task automatic scan(input logic w, input logic [5:0] a, input logic [3:0] n,
                      input logic [31:0] d);
    @(posedge clk_i);
    scan_i <= '{wr: w, rd: !w, addr: a, len: n, data: d};
    @(posedge clk_i);
    scan_i <= '{wr: 1'b0, rd: 1'b0, addr: ~a, len: ~n, data: ~d};
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // power-on: six cycles of reset, blink watch, then wait for run or stop
  task automatic boot(input logic v, input logic ok, input logic s, input logic [3:0] fa);
    int toggles;
    logic led;
    toggles = 0;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    fw_v20_i <= v;
    term_bus_ok_i <= ok;
    slow <= s;
    fail_at <= fa;
    repeat (5) @(posedge clk_i);
    #1;
    chk(fieldbus_start_o === 1'b0 && stopped_o === 1'b0, "outputs busy in reset");
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    led = io_err_led_o;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_i);
      #1;
      if (io_err_led_o !== led) toggles++;
      led = io_err_led_o;
    end
    chk(toggles >= 1, "error led not blinking in self-test");
    for (int i = 0; i < 2000 && fieldbus_start_o !== 1'b1 && stopped_o !== 1'b1; i++)
      @(posedge clk_i);
    #1;
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[ERR] %0t run timed out", $time);
      finish_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    for (int t = 0; t < 16; t++) begin
      ana_in_i[t] = 16'h0000;
      ana_stat_i[t] = 8'h00;
      for (int b = 0; b < 16; b++) dig_in_i[t][b] = 1'b0;
    end
    ana_in_i[0] = 16'h8123;
    ana_in_i[3] = 16'h7FFF;
    ana_stat_i[0] = 8'h44;
    dig_in_i[2][0] = 1'b1;
    dig_in_i[2][1] = 1'b1;
    dig_in_i[2][3] = 1'b1;
    boot(1'b1, 1'b1, 1'b0, 4'hF);
    chk(fieldbus_start_o === 1'b1 && stopped_o === 1'b0, "clean start not in run");
    for (int i = 0; i < 7; i++) begin
      scan(rows[i].wr, rows[i].addr, rows[i].len, rows[i].data);
      case (rows[i].kind)
        0: got = scan_rdata_o & ((rows[i].len >= 4'h4) ? 32'hFFFF_FFFF :
                                 ((32'h1 << (8 * rows[i].len)) - 32'h1));
        1: got = {16'h0000, ana_out_o[rows[i].idx]};
        default: got = {28'h0, dig_out_o[rows[i].idx][3], dig_out_o[rows[i].idx][2],
                        dig_out_o[rows[i].idx][1], dig_out_o[rows[i].idx][0]};
      endcase
      chk(got === rows[i].exp, "image row mismatch");
    end
    // back-to-back writes, each a whole word
    @(posedge clk_i);
    scan_i <= '{wr: 1'b1, rd: 1'b0, addr: 6'h00, len: 4'h2, data: 32'h0000_0001};
    @(posedge clk_i);
    scan_i <= '{wr: 1'b1, rd: 1'b0, addr: 6'h02, len: 4'h2, data: 32'h0000_0010};
    @(posedge clk_i);
    scan_i <= '0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(ana_out_o[0] === 16'h0001 && ana_out_o[3] === 16'h0010, "burst write lost");
    // probe fault in mid-chain, scanner write must be ignored
    boot(1'b1, 1'b1, 1'b0, 4'h1);
    chk(stopped_o === 1'b1 && fieldbus_start_o === 1'b0, "probe fault not stopped");
    scan(1'b1, 6'h00, 4'h2, 32'h0000_5555);
    repeat (200) @(posedge clk_i);
    chk(stopped_o === 1'b1 && ana_out_o[0] === 16'h0000, "stop left or write taken");
    boot(1'b1, 1'b0, 1'b0, 4'hF);
    chk(stopped_o === 1'b1 && fieldbus_start_o === 1'b0, "loop-back fault missed");
    // fresh power-on recovers; slow chain and control byte on top
    boot(1'b0, 1'b1, 1'b1, 4'hF);
    chk(fieldbus_start_o === 1'b1, "no run after new power-on");
    scan(1'b0, 6'h00, 4'h3, 32'h0);
    chk((scan_rdata_o & 32'h00FF_FFFF) === 32'h0044_8123, "status byte misplaced");
    scan(1'b1, 6'h00, 4'h3, 32'h0077_1234);
    chk(ana_ctrl_o[0] === 8'h77 && ana_out_o[0] === 16'h1234, "control byte lost");
    scan(1'b0, 6'h06, 4'h1, 32'h0);
    chk((scan_rdata_o & 32'h0000_000F) === 32'h0000_000B, "digital ins misplaced");
    finish_test();
  end
endmodule
